// file: src/cod_cfg.svh
// Field positions and encodings for the coprocessor opcode decoder.
// Assumes inclusion by bare name from the package and design files.
`ifndef COD_CFG_SVH
`define COD_CFG_SVH
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define COD_FUNC_HI   5
`define COD_FUNC_LO   0
`define COD_RS_HI     25
`define COD_RS_LO     21
`define COD_TF_BIT    16
// ----------------------------------------------------------------
// System coprocessor function codes
// ----------------------------------------------------------------
`define COD_F_TLBRD   6'h01
`define COD_F_TLB_WRITE_INDEXED   6'h02
`define COD_F_TLB_WRITE_RANDOM   6'h06
`define COD_F_TLBPR   6'h08
`define COD_F_ERTN    6'h18
`define COD_F_DRTN    6'h1f
`define COD_F_WAIT    6'h20
`define COD_F_EMPTY   6'h00
// ----------------------------------------------------------------
// Floating-point rs codes
// ----------------------------------------------------------------
`define COD_RS_MFR    5'h00
`define COD_RS_CFR    5'h02
`define COD_RS_HFR    5'h03
`define COD_RS_MTR    5'h04
`define COD_RS_CTR    5'h06
`define COD_RS_HTR    5'h07
`define COD_RS_BR     5'h08
`define COD_RS_S      5'h10
`define COD_RS_D      5'h11
`define COD_RS_W      5'h14
`define COD_RS_L      5'h15
// ----------------------------------------------------------------
// Floating-point function codes
// ----------------------------------------------------------------
`define COD_FN_ARITH_MAX 6'h0f
`define COD_FN_SQRT   6'h04
`define COD_FN_FLAG_CONDITIONAL_MOVE  6'h11
`define COD_FN_MOVZ   6'h12
`define COD_FN_MOVN   6'h13
`define COD_FN_RECIP  6'h15
`define COD_FN_RSQRT  6'h16
`define COD_FN_CVT_S  6'h20
`define COD_FN_CVT_D  6'h21
`define COD_FN_CVT_W  6'h24
`define COD_FN_CVT_L  6'h25
// Reset value of the registered result
`define COD_OP_RESET  6'h00
`endif

// file: src/cod_pkg.sv
// Types shared by the coprocessor opcode decoder files.
// Assumes cod_cfg.svh is on the include path.
package cod_pkg;
`include "cod_cfg.svh"
   // -------------------------------------------------------------
   // Decoded operation codes
   // -------------------------------------------------------------
   typedef enum logic [5:0] {
      COD_OP_NONE        = 6'h00,
      COD_OP_TLB_READ    = 6'h01,
      COD_OP_TLB_WR_IDX  = 6'h02,
      COD_OP_TLB_WR_RND  = 6'h03,
      COD_OP_TLB_PROBE   = 6'h04,
      COD_OP_EXC_RETURN  = 6'h05,
      COD_OP_DBG_RETURN  = 6'h06,
      COD_OP_WAIT_IDLE   = 6'h07,
      COD_OP_FPR_READ    = 6'h08,
      COD_OP_FPCTL_READ  = 6'h09,
      COD_OP_FPR_HI_READ = 6'h0a,
      COD_OP_FPR_WRITE   = 6'h0b,
      COD_OP_FPCTL_WRITE = 6'h0c,
      COD_OP_FPR_HI_WR   = 6'h0d,
      COD_OP_FP_BRANCH   = 6'h0e,
      COD_OP_ADD         = 6'h10,
      COD_OP_SUB         = 6'h11,
      COD_OP_MUL         = 6'h12,
      COD_OP_DIV         = 6'h13,
      COD_OP_SQRT        = 6'h14,
      COD_OP_ABS         = 6'h15,
      COD_OP_MOV         = 6'h16,
      COD_OP_NEG         = 6'h17,
      COD_OP_ROUND_L     = 6'h18,
      COD_OP_TRUNC_L     = 6'h19,
      COD_OP_CEIL_L      = 6'h1a,
      COD_OP_FLOOR_L     = 6'h1b,
      COD_OP_ROUND_W     = 6'h1c,
      COD_OP_TRUNC_W     = 6'h1d,
      COD_OP_CEIL_W      = 6'h1e,
      COD_OP_FLOOR_W     = 6'h1f,
      COD_OP_MOVE_FLAG_F = 6'h20,
      COD_OP_MOVE_FLAG_T = 6'h21,
      COD_OP_MOVE_ZERO   = 6'h22,
      COD_OP_MOVE_NZERO  = 6'h23,
      COD_OP_RECIP       = 6'h24,
      COD_OP_RSQRT       = 6'h25,
      COD_OP_CVT_S       = 6'h26,
      COD_OP_CVT_D       = 6'h27,
      COD_OP_CVT_W       = 6'h28,
      COD_OP_CVT_L       = 6'h29
   } cod_op_t;

   // Data format of a floating-point arithmetic word
   typedef enum logic [2:0] {
      COD_FMT_NONE = 3'h0,
      COD_FMT_S    = 3'h1,
      COD_FMT_D    = 3'h2,
      COD_FMT_W    = 3'h3,
      COD_FMT_L    = 3'h4
   } cod_fmt_t;

   // Incoming instruction word with its qualifiers
   typedef struct packed {
      logic        valid;
      logic        is_sys;
      logic        is_fp;
      logic [31:0] word;
   } cod_req_t;

   // Decoded result
   typedef struct packed {
      logic     valid;
      logic     reserved;
      cod_fmt_t fmt;
      cod_op_t  op;
   } cod_res_t;
endpackage

// file: src/cod_fp_func.sv
// Combinational function-field decoder for floating-point formats.
// Assumes the caller has already classified the rs field into a format.
`timescale 1ns/100ps
`include "cod_cfg.svh"
module cod_fp_func (
   // Inputs
   input  wire cod_pkg::cod_fmt_t fmt,
   input  wire logic [5:0]        func,
   input  wire logic              tf,
   // Outputs
   output cod_pkg::cod_op_t       op,
   output logic                   hit
);
   import cod_pkg::*;

   // --------------------------------------------------------------
   // Function decode per format
   // --------------------------------------------------------------
   always_comb begin
      op  = COD_OP_NONE;
      hit = 1'b0;
      if (fmt == COD_FMT_S || fmt == COD_FMT_D) begin
         // Arithmetic and rounding share one dense block
         if (func <= `COD_FN_ARITH_MAX) begin
            op  = cod_op_t'({2'b01, func[3:0]});
            hit = 1'b1;
         end else if (func == `COD_FN_FLAG_CONDITIONAL_MOVE) begin
            // Bit 16 picks the flag sense
            op  = tf ? COD_OP_MOVE_FLAG_T : COD_OP_MOVE_FLAG_F;
            hit = 1'b1;
         end else if (func == `COD_FN_MOVZ) begin
            op  = COD_OP_MOVE_ZERO;
            hit = 1'b1;
         end else if (func == `COD_FN_MOVN) begin
            op  = COD_OP_MOVE_NZERO;
            hit = 1'b1;
         end else if (func == `COD_FN_RECIP) begin
            op  = COD_OP_RECIP;
            hit = 1'b1;
         end else if (func == `COD_FN_RSQRT) begin
            op  = COD_OP_RSQRT;
            hit = 1'b1;
         end else if (func == `COD_FN_CVT_W) begin
            op  = COD_OP_CVT_W;
            hit = 1'b1;
         end else if (func == `COD_FN_CVT_L) begin
            op  = COD_OP_CVT_L;
            hit = 1'b1;
         end else if (fmt == COD_FMT_S && func == `COD_FN_CVT_D) begin
            op  = COD_OP_CVT_D;
            hit = 1'b1;
         end else if (fmt == COD_FMT_D && func == `COD_FN_CVT_S) begin
            op  = COD_OP_CVT_S;
            hit = 1'b1;
         end
      end else if (fmt == COD_FMT_W || fmt == COD_FMT_L) begin
         // Only the two conversions exist here
         if (func == `COD_FN_CVT_S) begin
            op  = COD_OP_CVT_S;
            hit = 1'b1;
         end else if (func == `COD_FN_CVT_D) begin
            op  = COD_OP_CVT_D;
            hit = 1'b1;
         end
      end
   end
endmodule

// file: src/cod_decoder.sv
// Coprocessor opcode decoder: system coprocessor operation format
// and floating-point coprocessor words, one registered result.
// Assumes request qualifiers come from logic on clk_sys.
`timescale 1ns/100ps
`include "cod_cfg.svh"

module cod_decoder (
   // Clock and reset
   input  wire logic          clk_sys,
   input  wire logic          rst,
   // Mode
   input  wire logic          fp64_en,
   // Request from issue stage
   input  wire cod_pkg::cod_req_t req,
   // Decoded result, registered
   output cod_pkg::cod_res_t  res
);
   import cod_pkg::*;

   // --------------------------------------------------------------
   // Field extraction
   // --------------------------------------------------------------
   function automatic logic [5:0] get_func(input logic [31:0] w);
      get_func = w[`COD_FUNC_HI:`COD_FUNC_LO];
   endfunction

   logic [4:0] rs_f;    // Floating-point rs field
   logic [5:0] fn_f;    // Function field
   cod_fmt_t   fmt_c;   // Format selected by rs
   cod_op_t    fp_op;   // Op from the format decoder
   logic       fp_hit;  // Format decoder found an op
   cod_res_t   res_reg; // Registered result
   cod_res_t   res_next;

   assign rs_f = req.word[`COD_RS_HI:`COD_RS_LO];
   assign fn_f = get_func(req.word);

   // --------------------------------------------------------------
   // Format classification
   // --------------------------------------------------------------
   // Long is dropped to no format when 64-bit mode is off, so
   // the function decoder never sees it and it falls to reserved.
   always_comb begin
      fmt_c = COD_FMT_NONE;
      if (rs_f == `COD_RS_S) begin
         fmt_c = COD_FMT_S;
      end else if (rs_f == `COD_RS_D) begin
         fmt_c = COD_FMT_D;
      end else if (rs_f == `COD_RS_W) begin
         fmt_c = COD_FMT_W;
      end else if (rs_f == `COD_RS_L && fp64_en) begin
         fmt_c = COD_FMT_L;
      end
   end

   cod_fp_func u_fp_func (
      .fmt  (fmt_c),
      .func (fn_f),
      .tf   (req.word[`COD_TF_BIT]),
      .op   (fp_op),
      .hit  (fp_hit)
   );

   // --------------------------------------------------------------
   // Next result
   // --------------------------------------------------------------
   always_comb begin
      res_next          = '0;
      res_next.op       = COD_OP_NONE;
      res_next.fmt      = COD_FMT_NONE;
      res_next.valid    = req.valid;
      res_next.reserved = 1'b0;
      if (req.valid && req.is_sys) begin
         // System coprocessor operation format
         case (fn_f)
            `COD_F_TLBRD: res_next.op = COD_OP_TLB_READ;
            `COD_F_TLB_WRITE_INDEXED: res_next.op = COD_OP_TLB_WR_IDX;
            `COD_F_TLB_WRITE_RANDOM: res_next.op = COD_OP_TLB_WR_RND;
            `COD_F_TLBPR: res_next.op = COD_OP_TLB_PROBE;
            `COD_F_ERTN:  res_next.op = COD_OP_EXC_RETURN;
            `COD_F_DRTN:  res_next.op = COD_OP_DBG_RETURN;
            `COD_F_WAIT:  res_next.op = COD_OP_WAIT_IDLE;
            default:      res_next.reserved = 1'b1;
         endcase
      end else if (req.valid && req.is_fp) begin
         case (rs_f)
            `COD_RS_MFR: res_next.op = COD_OP_FPR_READ;
            `COD_RS_CFR: res_next.op = COD_OP_FPCTL_READ;
            `COD_RS_HFR: res_next.op = COD_OP_FPR_HI_READ;
            `COD_RS_MTR: res_next.op = COD_OP_FPR_WRITE;
            `COD_RS_CTR: res_next.op = COD_OP_FPCTL_WRITE;
            `COD_RS_HTR: res_next.op = COD_OP_FPR_HI_WR;
            `COD_RS_BR:  res_next.op = COD_OP_FP_BRANCH;
            default: begin
               // Formats, with long gated by mode
               if (fp_hit) begin
                  res_next.op  = fp_op;
                  res_next.fmt = fmt_c;
               end else begin
                  res_next.reserved = 1'b1;
               end
            end
         endcase
      end
   end

   // --------------------------------------------------------------
   // Result register
   // --------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         res_reg <= '0;
      end else begin
         res_reg <= res_next;
      end
   end

   assign res = res_reg;

   // --------------------------------------------------------------
   // Checks
   // --------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   a_sys_wait_op: assert property (
      req.valid && req.is_sys && fn_f == `COD_F_WAIT |=>
      res.valid && res.op == COD_OP_WAIT_IDLE && !res.reserved)
      else $error("wait code not decoded");

   a_sys_gap_rsv: assert property (
      req.valid && req.is_sys && fn_f == `COD_F_EMPTY |=> res.reserved)
      else $error("sys code zero not reserved");

   a_fp_branch: assert property (
      req.valid && req.is_fp && !req.is_sys && rs_f == `COD_RS_BR |=>
      res.op == COD_OP_FP_BRANCH && !res.reserved)
      else $error("fp branch not decoded");

   a_fp_sqrt_op: assert property (
      req.valid && req.is_fp && !req.is_sys && rs_f == `COD_RS_D &&
      fn_f == `COD_FN_SQRT |=> res.op == COD_OP_SQRT && res.fmt == COD_FMT_D)
      else $error("sqrt not decoded");

   a_single_cvtd: assert property (
      req.valid && req.is_fp && !req.is_sys && rs_f == `COD_RS_S &&
      fn_f == `COD_FN_CVT_D |=> res.op == COD_OP_CVT_D)
      else $error("single to double not decoded");

   a_double_cvtd: assert property (
      req.valid && req.is_fp && !req.is_sys && rs_f == `COD_RS_D &&
      fn_f == `COD_FN_CVT_D |=> res.reserved)
      else $error("double to double not reserved");

   a_word_only_cvt: assert property (
      req.valid && req.is_fp && !req.is_sys && rs_f == `COD_RS_W &&
      fn_f != `COD_FN_CVT_S && fn_f != `COD_FN_CVT_D |=> res.reserved)
      else $error("word format accepted bad function");

   a_long_gated: assert property (
      req.valid && req.is_fp && !req.is_sys && rs_f == `COD_RS_L &&
      !fp64_en |=> res.reserved && res.fmt == COD_FMT_NONE)
      else $error("long accepted without 64-bit mode");

   a_flag_conditional_move_sense: assert property (
      req.valid && req.is_fp && !req.is_sys && rs_f == `COD_RS_S &&
      fn_f == `COD_FN_FLAG_CONDITIONAL_MOVE |=>
      res.op == ($past(req.word[`COD_TF_BIT]) ? COD_OP_MOVE_FLAG_T
                                              : COD_OP_MOVE_FLAG_F))
      else $error("flag move sense wrong");

   a_rsv_no_op: assert property (
      res.reserved |-> res.valid && res.op == COD_OP_NONE)
      else $error("reserved with an op");

   // Random-slot TLB write has its own code
   a_tlb_rnd_op: assert property (
      req.valid && req.is_sys && fn_f == `COD_F_TLB_WRITE_RANDOM |=>
      res.op == COD_OP_TLB_WR_RND && !res.reserved)
      else $error("random tlb write not decoded");

   // Control-register write is a move, so it carries no format
   a_fpctl_wr_op: assert property (
      req.valid && req.is_fp && !req.is_sys && rs_f == `COD_RS_CTR |=>
      res.op == COD_OP_FPCTL_WRITE && res.fmt == COD_FMT_NONE)
      else $error("fp control write not decoded");

   // Double keeps the reciprocal of the single map
   a_dbl_recip_op: assert property (
      req.valid && req.is_fp && !req.is_sys && rs_f == `COD_RS_D &&
      fn_f == `COD_FN_RECIP |=>
      res.op == COD_OP_RECIP && res.fmt == COD_FMT_D)
      else $error("double reciprocal not decoded");

   // Word converts up to double as well as single
   a_word_cvt_d: assert property (
      req.valid && req.is_fp && !req.is_sys && rs_f == `COD_RS_W &&
      fn_f == `COD_FN_CVT_D |=>
      res.op == COD_OP_CVT_D && res.fmt == COD_FMT_W && !res.reserved)
      else $error("word to double not decoded");

   // With 64-bit mode on, long is an ordinary format
   a_long_legal: assert property (
      req.valid && req.is_fp && !req.is_sys && rs_f == `COD_RS_L &&
      fp64_en && fn_f == `COD_FN_CVT_S |=>
      res.op == COD_OP_CVT_S && res.fmt == COD_FMT_L)
      else $error("long refused in 64-bit mode");

   // A clear tf bit selects the flag-false move in double
   a_flag_false: assert property (
      req.valid && req.is_fp && !req.is_sys && rs_f == `COD_RS_D &&
      fn_f == `COD_FN_FLAG_CONDITIONAL_MOVE && !req.word[`COD_TF_BIT] |=>
      res.op == COD_OP_MOVE_FLAG_F && res.fmt == COD_FMT_D)
      else $error("flag-false move not decoded");

   // A word with no coprocessor flag must not trap
   a_plain_word: assert property (
      req.valid && !req.is_sys && !req.is_fp |=>
      res.valid && !res.reserved && res.op == COD_OP_NONE)
      else $error("unflagged word decoded or trapped");

   // An idle cycle leaves an empty result behind
   a_idle_empty: assert property (
      !req.valid |=> !res.valid && !res.reserved && res.op == COD_OP_NONE)
      else $error("idle cycle left a result");
endmodule

// file: verification/cod_issue_model.sv
// Partner model: the issue stage that hands words to the decoder.
// Assumes the bench calls put and rest just after a rising edge.
`timescale 1ns/100ps
module cod_issue_model (
   // Clock
   input  wire logic         clk_sys,
   // Request to the decoder
   output cod_pkg::cod_req_t req
);
   import cod_pkg::*;
   // -------------------------------------------------------------
   // Drive tasks
   // -------------------------------------------------------------
   // Quiet bus until the first word
   initial begin
      req = '0;
   end
   // Present one word; it stands until the next call
   task automatic put(input logic s, input logic f, input logic [31:0] w);
      req <= '{valid: 1'b1, is_sys: s, is_fp: f, word: w};
   endtask
   // Drop the word; invert the rest so stale bits never pass as live
   task automatic rest();
      req <= '{valid: 1'b0, is_sys: ~req.is_sys, is_fp: ~req.is_fp,
               word: ~req.word};
   endtask
endmodule

// file: verification/tb_top.sv
// Self-checking bench for the coprocessor opcode decoder.
// Assumes cod_pkg is compiled first and the issue model beside it.
`timescale 1ns/100ps
module tb_top;
   import cod_pkg::*;
   // -------------------------------------------------------------
   // Signals
   // -------------------------------------------------------------
   logic      clk_sys = 1'b0; // 25 MHz system clock
   logic      rst     = 1'b1; // Synchronous reset
   logic      fp64_en = 1'b0; // 64-bit FP mode
   cod_req_t  req;            // Word from the issue model
   cod_res_t  res;            // Registered decode result
   int        err_total = 0;  // Mismatches
   int        cmp_count = 0;  // Comparisons
   // Clock, 40 ns period
   always begin
      #20 clk_sys = ~clk_sys;
   end
   cod_issue_model u_src (.clk_sys(clk_sys), .req(req));
   cod_decoder u_dut (.clk_sys(clk_sys), .rst(rst), .fp64_en(fp64_en),
                      .req(req), .res(res));
   // -------------------------------------------------------------
   // Expected values, worked out from the encoding tables
   // -------------------------------------------------------------
   function automatic cod_res_t mk(cod_fmt_t f, cod_op_t o);
      mk = '{valid: 1'b1, reserved: (o == COD_OP_NONE), fmt: f, op: o};
      // Reserved words carry no format
      if (o == COD_OP_NONE) begin
         mk.fmt = COD_FMT_NONE;
      end
   endfunction
   function automatic cod_op_t exp_sys(logic [5:0] fn);
      case (fn)
         6'h01:   exp_sys = COD_OP_TLB_READ;
         6'h02:   exp_sys = COD_OP_TLB_WR_IDX;
         6'h06:   exp_sys = COD_OP_TLB_WR_RND;
         6'h08:   exp_sys = COD_OP_TLB_PROBE;
         6'h18:   exp_sys = COD_OP_EXC_RETURN;
         6'h1f:   exp_sys = COD_OP_DBG_RETURN;
         6'h20:   exp_sys = COD_OP_WAIT_IDLE;
         default: exp_sys = COD_OP_NONE;
      endcase
   endfunction
   function automatic cod_res_t exp_fp(logic [4:0] rs, logic [5:0] fn,
                                       logic tf, logic f64);
      cod_fmt_t f;
      cod_op_t  o;
      f = COD_FMT_NONE;
      o = COD_OP_NONE;
      case (rs)
         5'h00: o = COD_OP_FPR_READ;
         5'h02: o = COD_OP_FPCTL_READ;
         5'h03: o = COD_OP_FPR_HI_READ;
         5'h04: o = COD_OP_FPR_WRITE;
         5'h06: o = COD_OP_FPCTL_WRITE;
         5'h07: o = COD_OP_FPR_HI_WR;
         5'h08: o = COD_OP_FP_BRANCH;
         5'h10: f = COD_FMT_S;
         5'h11: f = COD_FMT_D;
         5'h14: f = COD_FMT_W;
         5'h15: f = f64 ? COD_FMT_L : COD_FMT_NONE;
         default: o = COD_OP_NONE;
      endcase
      // Single and double share most of the function map
      if (f == COD_FMT_S || f == COD_FMT_D) begin
         if (fn < 6'h10) begin
            o = cod_op_t'(6'h10 + fn);
         end else begin
            case (fn)
               6'h11: o = tf ? COD_OP_MOVE_FLAG_T : COD_OP_MOVE_FLAG_F;
               6'h12: o = COD_OP_MOVE_ZERO;
               6'h13: o = COD_OP_MOVE_NZERO;
               6'h15: o = COD_OP_RECIP;
               6'h16: o = COD_OP_RSQRT;
               6'h20: o = (f == COD_FMT_D) ? COD_OP_CVT_S : COD_OP_NONE;
               6'h21: o = (f == COD_FMT_S) ? COD_OP_CVT_D : COD_OP_NONE;
               6'h24: o = COD_OP_CVT_W;
               6'h25: o = COD_OP_CVT_L;
               default: o = COD_OP_NONE;
            endcase
         end
      end else if (f != COD_FMT_NONE) begin
         // Word and long only convert up
         o = (fn == 6'h20) ? COD_OP_CVT_S :
             (fn == 6'h21) ? COD_OP_CVT_D : COD_OP_NONE;
      end
      exp_fp = mk(f, o);
   endfunction
   function automatic logic [31:0] fpw(logic [4:0] rs, logic tf,
                                       logic [5:0] fn);
      fpw = {6'h11, rs, 4'h0, tf, 10'h000, fn};
   endfunction
   // -------------------------------------------------------------
   // Compare and drive tasks
   // -------------------------------------------------------------
   task automatic chk_res(input cod_res_t got, input cod_res_t e);
      cmp_count++;
      if (got !== e) begin
         err_total++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, e);
      end
   endtask
   task automatic dec(input logic s, input logic f, input logic f64,
                      input logic [31:0] w, input cod_res_t e);
      @(posedge clk_sys);
      fp64_en <= f64;
      u_src.put(s, f, w);
      @(posedge clk_sys);
      #1;
      chk_res(res, e);
   endtask
   // -------------------------------------------------------------
   // Scenarios
   // -------------------------------------------------------------
   // Every system function code; odd codes also raise is_fp
   task automatic t_sys();
      for (int i = 0; i < 64; i++) begin
         dec(1'b1, i[0], 1'b0, {6'h10, 1'b1, 19'h0, i[5:0]},
             mk(COD_FMT_NONE, exp_sys(i[5:0])));
      end
   endtask
   // Every rs code, with the convert-to-single function
   task automatic t_rs();
      for (int i = 0; i < 32; i++) begin
         dec(1'b0, 1'b1, 1'b1, fpw(i[4:0], 1'b0, 6'h20),
             exp_fp(i[4:0], 6'h20, 1'b0, 1'b1));
      end
   endtask
   // Every function code and tf value in all four formats
   task automatic t_fmt();
      logic [4:0] fm [4] = '{5'h10, 5'h11, 5'h14, 5'h15};
      for (int k = 0; k < 4; k++) begin
         for (int i = 0; i < 128; i++) begin
            dec(1'b0, 1'b1, 1'b1, fpw(fm[k], i[6], i[5:0]),
                exp_fp(fm[k], i[5:0], i[6], 1'b1));
         end
      end
   endtask
   // Long format with 64-bit mode off must trap
   task automatic t_long();
      dec(1'b0, 1'b1, 1'b0, fpw(5'h15, 1'b0, 6'h20),
          mk(COD_FMT_NONE, COD_OP_NONE));
      dec(1'b0, 1'b1, 1'b0, fpw(5'h15, 1'b0, 6'h21),
          mk(COD_FMT_NONE, COD_OP_NONE));
   endtask
   // Back-to-back words, an unflagged word, then an idle cycle
   task automatic t_b2b();
      @(posedge clk_sys);
      u_src.put(1'b1, 1'b0, 32'h4200_0020);
      @(posedge clk_sys);
      u_src.put(1'b0, 1'b1, fpw(5'h10, 1'b1, 6'h11));
      #1;
      chk_res(res, mk(COD_FMT_NONE, COD_OP_WAIT_IDLE));
      @(posedge clk_sys);
      u_src.put(1'b0, 1'b0, 32'hffff_ffff);
      #1;
      chk_res(res, mk(COD_FMT_S, COD_OP_MOVE_FLAG_T));
      @(posedge clk_sys);
      u_src.rest();
      #1;
      chk_res(res, '{1'b1, 1'b0, COD_FMT_NONE, COD_OP_NONE});
      @(posedge clk_sys);
      #1;
      chk_res(res, '0);
   endtask
   // Reset in mid-run clears the result, then decoding resumes
   task automatic t_rst();
      @(posedge clk_sys);
      u_src.put(1'b1, 1'b0, 32'h4200_0018);
      @(posedge clk_sys);
      rst <= 1'b1;
      #1;
      chk_res(res, mk(COD_FMT_NONE, COD_OP_EXC_RETURN));
      @(posedge clk_sys);
      rst <= 1'b0;
      #1;
      chk_res(res, '0);
      @(posedge clk_sys);
      u_src.rest();
      #1;
      chk_res(res, mk(COD_FMT_NONE, COD_OP_EXC_RETURN));
      @(posedge clk_sys);
      #1;
      chk_res(res, '0);
   endtask
   // -------------------------------------------------------------
   // Verdict, main sequence and watchdog
   // -------------------------------------------------------------
   task automatic results();
      $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge clk_sys);
      rst <= 1'b0;
      #1;
      chk_res(res, '0);
      t_sys();
      t_rs();
      t_fmt();
      t_long();
      t_b2b();
      t_rst();
      results();
   end
   // Run needs about 610 words at two cycles each
   initial begin
      #(40 * 6000);
      err_total++;
      results();
   end
endmodule
